// ### xdas_pkg.sv
// Constants shared by the external data access stretch and wait block.
`default_nettype none
package xdas_pkg;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [1:0] PHASE_THIRD = 2'h2;
	localparam logic [1:0] PHASE_STRB_S0 = 2'h0;
	localparam logic [1:0] PHASE_STRB_SN = 2'h1;
	localparam logic [1:0] PHASE_END_S0 = 2'h2;
	localparam logic [1:0] PHASE_END_SN = 2'h1;
	localparam int unsigned FETCH_CLOCKS = 4;
	localparam int unsigned STRETCH_LSB = 0;
	localparam int unsigned STRETCH_MSB = 2;
	localparam logic [2:0] STRETCH_RST = 3'h1;
	localparam int unsigned WAIT_EN_BIT = 7;
	localparam logic WAIT_EN_RST = 1'b0;
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [7:0] DATA_RST = 8'h00;
	typedef enum logic [2:0] {
		XDAS_IDLE = 3'h1,
		XDAS_FETCH = 3'h2,
		XDAS_ACCESS = 3'h4
	} xdas_state_e;
endpackage : xdas_pkg
`default_nettype wire

// ### xdas_sync.sv
// Two flip-flop synchroniser for one level arriving from a pin.
`timescale 1ns/1ps
`default_nettype none
module xdas_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_i,
	// Level in and out.
	input wire logic async_i,
	output logic sync_o
);
	logic meta_r;
	logic sync_r;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta_r <= RESET_VAL;
			sync_r <= RESET_VAL;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end

	assign sync_o = sync_r;
endmodule : xdas_sync
`default_nettype wire

// ### xdas_ctrl.sv
// External data move timing: stretch, strobe generation and wait insertion.
`timescale 1ns/1ps
`default_nettype none
module xdas_ctrl (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_i,
	// Core register writes and read-back.
	input wire logic clock_control_we_i,
	input wire logic [7:0] clock_control_wdata_i,
	input wire logic mmap_we_i,
	input wire logic [7:0] mmap_wdata_i,
	input wire logic timed_access_ok_i,
	output logic [7:0] clock_control_reg_o,
	output logic [7:0] memory_map_reg_o,
	// Core move request and answer.
	input wire logic move_start_i,
	input wire logic move_write_i,
	input wire logic [15:0] move_addr_i,
	input wire logic [7:0] move_wdata_i,
	output logic move_ready_o,
	output logic cpu_hold_o,
	output logic move_done_o,
	output logic [7:0] move_rdata_o,
	output logic [1:0] phase_o,
	// External memory pins.
	output logic [15:0] ext_addr_o,
	output logic ext_rd_n_o,
	output logic ext_wr_n_o,
	input wire logic [7:0] ext_data_i,
	output logic [7:0] ext_data_o,
	output logic ext_data_oe_n_o,
	input wire logic aux_port_bit0_wait_n_i
);
	////////////////////////////////////////////////////////////////////////
	logic [2:0] stretch_select_r;
	logic wait_input_enable_r;
	logic [1:0] phase_r;
	xdas_pkg::xdas_state_e state_r;
	logic [2:0] s_r;
	logic [2:0] rem_r;
	logic first_r;
	logic wr_r;
	logic strobe_r;
	logic wait_hit_r;
	logic [15:0] addr_r;
	logic [7:0] wdata_r;
	logic [7:0] rdata_r;
	logic wait_sync;
	logic s_zero;
	logic wait_now;
	logic strobe_set;
	logic strobe_clr;
	logic accept;

	xdas_sync #(.RESET_VAL(1'b1)) u_wait_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.async_i(aux_port_bit0_wait_n_i),
		.sync_o(wait_sync)
	);

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			stretch_select_r <= xdas_pkg::STRETCH_RST;
		end else if (clock_control_we_i) begin
			stretch_select_r <= clock_control_wdata_i[xdas_pkg::STRETCH_MSB:
				xdas_pkg::STRETCH_LSB];
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wait_input_enable_r <= xdas_pkg::WAIT_EN_RST;
		end else if (mmap_we_i && timed_access_ok_i) begin
			wait_input_enable_r <= mmap_wdata_i[xdas_pkg::WAIT_EN_BIT];
		end
	end

	assign clock_control_reg_o = {5'h00, stretch_select_r};
	assign memory_map_reg_o = {wait_input_enable_r, 7'h00};

	////////////////////////////////////////////////////////////////////////
	// The machine cycle clock runs free so every other instruction keeps
	// its four-clock rhythm; only the core's hold stretches the move.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			phase_r <= 2'h0;
		end else begin
			phase_r <= phase_r + 2'h1;
		end
	end

	assign phase_o = phase_r;
	assign s_zero = (s_r == 3'h0);
	assign move_ready_o = (state_r == xdas_pkg::XDAS_IDLE) &&
		(phase_r == xdas_pkg::PHASE_LAST);
	assign accept = move_ready_o && move_start_i;
	assign cpu_hold_o = (state_r != xdas_pkg::XDAS_IDLE);

	// Sampling looks at the synchronised pin in the third phase of the cycle
	// whose strobe edge is next due, and only while a move is in its access.
	assign wait_now = wait_input_enable_r && !wait_sync &&
		(state_r == xdas_pkg::XDAS_ACCESS) &&
		(phase_r == xdas_pkg::PHASE_THIRD) &&
		(rem_r == (s_zero ? 3'h0 : 3'h1));

	assign move_done_o = (state_r == xdas_pkg::XDAS_ACCESS) &&
		(phase_r == xdas_pkg::PHASE_LAST) && (rem_r == 3'h0) && !wait_hit_r;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_r <= xdas_pkg::XDAS_IDLE;
		end else begin
			case (state_r)
				xdas_pkg::XDAS_IDLE: begin
					if (accept) begin
						state_r <= xdas_pkg::XDAS_FETCH;
					end
				end
				xdas_pkg::XDAS_FETCH: begin
					if (phase_r == xdas_pkg::PHASE_LAST) begin
						state_r <= xdas_pkg::XDAS_ACCESS;
					end
				end
				xdas_pkg::XDAS_ACCESS: begin
					if (move_done_o) begin
						state_r <= xdas_pkg::XDAS_IDLE;
					end
				end
				default: begin
					state_r <= xdas_pkg::XDAS_IDLE;
				end
			endcase
		end
	end

	// Stretch is latched per move so a write during the move cannot tear it.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_r <= xdas_pkg::STRETCH_RST;
			rem_r <= 3'h0;
			first_r <= 1'b0;
		end else if (accept) begin
			s_r <= stretch_select_r;
			rem_r <= stretch_select_r;
			first_r <= 1'b1;
		end else if (state_r == xdas_pkg::XDAS_ACCESS &&
			phase_r == xdas_pkg::PHASE_LAST) begin
			first_r <= 1'b0;
			if (!wait_hit_r && rem_r != 3'h0) begin
				rem_r <= rem_r - 3'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wait_hit_r <= 1'b0;
		end else if (wait_now) begin
			wait_hit_r <= 1'b1;
		end else if (phase_r == xdas_pkg::PHASE_LAST) begin
			wait_hit_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign strobe_set = (state_r == xdas_pkg::XDAS_ACCESS) && first_r &&
		(phase_r == (s_zero ? xdas_pkg::PHASE_STRB_S0 :
		xdas_pkg::PHASE_STRB_SN));
	assign strobe_clr = strobe_r && (rem_r == 3'h0) && !wait_now &&
		(phase_r == (s_zero ? xdas_pkg::PHASE_END_S0 :
		xdas_pkg::PHASE_END_SN));

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			strobe_r <= 1'b0;
		end else if (strobe_set) begin
			strobe_r <= 1'b1;
		end else if (strobe_clr) begin
			strobe_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			addr_r <= xdas_pkg::ADDR_RST;
			wdata_r <= xdas_pkg::DATA_RST;
			wr_r <= 1'b0;
		end else if (accept) begin
			addr_r <= move_addr_i;
			wdata_r <= move_wdata_i;
			wr_r <= move_write_i;
		end
	end

	// Read data is caught on the strobe's closing edge, when it is stable.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_r <= xdas_pkg::DATA_RST;
		end else if (strobe_clr && !wr_r) begin
			rdata_r <= ext_data_i;
		end
	end

	assign ext_addr_o = addr_r;
	assign ext_data_o = wdata_r;
	assign ext_data_oe_n_o = !(wr_r && state_r == xdas_pkg::XDAS_ACCESS);
	assign ext_rd_n_o = !(strobe_r && !wr_r);
	assign ext_wr_n_o = !(strobe_r && wr_r);
	assign move_rdata_o = rdata_r;

	////////////////////////////////////////////////////////////////////////
	logic [15:0] cyc_r;
	logic [15:0] waits_r;
	logic [15:0] width_r;
	logic [15:0] wwidth_r;

	always_ff @(posedge clk_i) begin
		if (reset_i || accept) begin
			cyc_r <= 16'h0000;
			waits_r <= 16'h0000;
		end else if (state_r != xdas_pkg::XDAS_IDLE) begin
			cyc_r <= cyc_r + 16'h0001;
			if (wait_now) begin
				waits_r <= waits_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || strobe_set) begin
			width_r <= 16'h0001;
			wwidth_r <= 16'h0000;
		end else if (strobe_r) begin
			width_r <= width_r + 16'h0001;
			if (wait_now) begin
				wwidth_r <= wwidth_r + 16'h0004;
			end
		end
	end

	sequence seq_fetch;
		(state_r == xdas_pkg::XDAS_FETCH) [*4];
	endsequence

	sequence seq_access_open;
		(state_r == xdas_pkg::XDAS_ACCESS) && first_r;
	endsequence

	a_fetch_then_access: assert property (@(posedge clk_i) disable iff (reset_i)
		accept |=> seq_fetch ##1 seq_access_open)
		else $error("fetch cycle is not four clocks");

	a_addr_on_access: assert property (@(posedge clk_i) disable iff (reset_i)
		accept |-> ##5 (ext_addr_o == $past(move_addr_i, 5)))
		else $error("access address does not match request");

	a_move_length: assert property (@(posedge clk_i) disable iff (reset_i)
		move_done_o |-> (cyc_r + 16'h0001 ==
		({13'h0000, s_r} + 16'h0002 + waits_r) * 16'h0004))
		else $error("move length differs from stretch plus two");

	a_reset_stretch: assert property (@(posedge clk_i)
		reset_i |=> (clock_control_reg_o == 8'h01))
		else $error("stretch not one after reset");

	a_idle_no_strobe: assert property (@(posedge clk_i) disable iff (reset_i)
		(state_r == xdas_pkg::XDAS_IDLE) |-> (ext_rd_n_o && ext_wr_n_o))
		else $error("strobe active outside a move");

	a_strobe_width: assert property (@(posedge clk_i) disable iff (reset_i)
		strobe_clr |-> (width_r == wwidth_r + (s_zero ? 16'h0002 :
		{11'h000, s_r, 2'h0})))
		else $error("strobe width wrong for stretch");

	a_wait_phase: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(wait_hit_r) |-> ($past(phase_r) == xdas_pkg::PHASE_THIRD) &&
		$past(strobe_r))
		else $error("wait sampled outside third phase of strobe");

	a_wait_inserts: assert property (@(posedge clk_i) disable iff (reset_i)
		wait_now |=> !move_done_o ##1 (state_r == xdas_pkg::XDAS_ACCESS)
		[*4])
		else $error("wait did not insert a machine cycle");

	a_wait_disabled: assert property (@(posedge clk_i) disable iff (reset_i)
		!wait_input_enable_r |-> !wait_now)
		else $error("disabled wait affected timing");

	a_enable_protect: assert property (@(posedge clk_i) disable iff (reset_i)
		!timed_access_ok_i |=> $stable(wait_input_enable_r))
		else $error("wait enable changed without timed access");
endmodule : xdas_ctrl
`default_nettype wire

// ### xdas_ram_model.sv
// Behavioural external data RAM that can hold the move with its wait pin.
`timescale 1ns/1ps
`default_nettype none
module xdas_ram_model (
	// Clock.
	input wire logic clk_i,
	// Memory pins.
	input wire logic [15:0] ext_addr_i,
	input wire logic ext_rd_n_i,
	input wire logic ext_wr_n_i,
	input wire logic [7:0] ext_data_i,
	input wire logic ext_data_oe_n_i,
	output logic [7:0] ext_data_o,
	// Wait request: hold the pin low for so many clocks.
	input wire logic wait_go_i,
	input wire logic [7:0] wait_clks_i,
	output logic wait_n_o
);
	logic [7:0] mem_r [16];
	logic [7:0] last_r = 8'h00;
	logic [7:0] cnt_r = 8'h00;
	initial for (int i = 0; i < 16; i++) mem_r[i] = 8'h00;
	// A released bus shows the inverse of its last value, so no stale hold.
	assign ext_data_o = ext_rd_n_i ? ~last_r : mem_r[ext_addr_i[3:0]];
	assign wait_n_o = (cnt_r == 8'h00);
	always @(posedge clk_i) begin
		if (!ext_rd_n_i)
			last_r <= mem_r[ext_addr_i[3:0]];
		if (!ext_wr_n_i && !ext_data_oe_n_i)
			mem_r[ext_addr_i[3:0]] <= ext_data_i;
		if (wait_go_i)
			cnt_r <= wait_clks_i;
		else if (cnt_r != 8'h00)
			cnt_r <= cnt_r - 8'h01;
	end
endmodule : xdas_ram_model
`default_nettype wire

// ### tb_xdas_ctrl.sv
// Self-checking bench for the external data move timing block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	miscompares++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_xdas_ctrl;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ck_we = 1'b0, mm_we = 1'b0, ta_ok = 1'b0, st = 1'b0, wr = 1'b0;
	logic [7:0] ck_wd = 8'h00, mm_wd = 8'h00, wd = 8'h00, wclks = 8'h00;
	logic [15:0] addr = 16'h0000;
	logic go = 1'b0;
	logic [7:0] ck_q, mm_q, rd, di, dout;
	logic rdy, hold, done, rd_n, wr_n, oe_n, wait_n;
	logic [1:0] ph;
	logic [15:0] ea;
	logic [7:0] shadow [16];
	logic [31:0] lf = 32'h2226;
	int miscompares = 0, n_checks = 0, sw = 0, cyc = 0, cs = 1, wen = 0;
	xdas_ctrl dut_u (.clk_i(clk), .reset_i(rst),
		.clock_control_we_i(ck_we), .clock_control_wdata_i(ck_wd),
		.mmap_we_i(mm_we), .mmap_wdata_i(mm_wd),
		.timed_access_ok_i(ta_ok), .clock_control_reg_o(ck_q),
		.memory_map_reg_o(mm_q), .move_start_i(st), .move_write_i(wr),
		.move_addr_i(addr), .move_wdata_i(wd), .move_ready_o(rdy),
		.cpu_hold_o(hold), .move_done_o(done), .move_rdata_o(rd),
		.phase_o(ph), .ext_addr_o(ea), .ext_rd_n_o(rd_n), .ext_wr_n_o(wr_n),
		.ext_data_i(di), .ext_data_o(dout), .ext_data_oe_n_o(oe_n),
		.aux_port_bit0_wait_n_i(wait_n));
	xdas_ram_model ram_u (.clk_i(clk), .ext_addr_i(ea), .ext_rd_n_i(rd_n),
		.ext_wr_n_i(wr_n), .ext_data_i(dout), .ext_data_oe_n_i(oe_n),
		.ext_data_o(di), .wait_go_i(go), .wait_clks_i(wclks),
		.wait_n_o(wait_n));
	always #2 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	function automatic int exp_clks(input int s, input int w);
		return 4 * (s + 2 + w);
	endfunction : exp_clks
	function automatic int exp_sw(input int s, input int w);
		return ((s == 0) ? 2 : 4 * s) + 4 * w;
	endfunction : exp_sw
	task automatic conclude();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	task automatic tick();
		@(posedge clk) #1;
	endtask : tick
	// Strobe width is counted here; a write must drive data while strobed.
	always @(posedge clk) begin
		cyc++;
		if (!rd_n || !wr_n)
			sw++;
		if (!wr_n)
			`CHK("write drive", 1'b0, oe_n)
		if (cyc == 10000) begin
			miscompares++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic regw(input logic m, input logic [7:0] d, input logic ok);
		ck_we = !m;
		mm_we = m;
		ck_wd = d;
		mm_wd = d;
		ta_ok = ok;
		if (!m)
			cs = d[2:0];
		else if (ok)
			wen = d[7];
		tick();
		ck_we = 1'b0;
		mm_we = 1'b0;
		ta_ok = 1'b0;
		// An idle edge, with both write enables low, comes before the read-back checks.
		tick();
		`CHK("clock control", {5'h00, 3'(cs)}, ck_q)
		`CHK("memory map", {1'(wen), 7'h00}, mm_q)
	endtask : regw
	task automatic move(input logic w_, input int wt, input logic [15:0] a,
		input logic [7:0] d);
		int n;
		int se;
		n = 0;
		se = (cs == 0) ? 1 : cs;
		while (rdy !== 1'b1 && n < 20) begin
			tick();
			n++;
		end
		`CHK("ready", 1'b1, rdy)
		st = 1'b1;
		wr = w_;
		addr = a;
		wd = d;
		go = (wt > 0);
		wclks = 8'(4 * (se + wt - 1) + 3);
		tick();
		st = 1'b0;
		go = 1'b0;
		`CHK("fetch phase", 2'h0, ph)
		`CHK("hold in move", 1'b1, hold)
		sw = 0;
		n = 1;
		while (done !== 1'b1 && n < 300) begin
			tick();
			n++;
		end
		`CHK("move clocks", exp_clks(cs, wen ? wt : 0), n)
		`CHK("strobe clocks", exp_sw(cs, wen ? wt : 0), sw)
		`CHK("address", a, ea)
		if (!w_)
			`CHK("read data", shadow[a[3:0]], rd)
		else
			shadow[a[3:0]] = d;
		tick();
		`CHK("hold", 1'b0, hold)
		`CHK("done pulse", 1'b0, done)
	endtask : move
	////////////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 16; i++)
			shadow[i] = 8'h00;
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		`CHK("stretch reset", 8'h01, ck_q)
		`CHK("wait enable reset", 8'h00, mm_q)
		move(1'b0, 2, 16'h0003, 8'h00);
		for (int s = 0; s < 8; s++) begin
			lf = lfsr(lf);
			regw(1'b0, {lf[7:3], 3'(s)}, 1'b0);
			move(1'b1, 0, lf[23:8], lf[31:24]);
			move(1'b0, 0, lf[23:8], 8'h00);
		end
		regw(1'b1, 8'h80, 1'b0);
		move(1'b0, 3, 16'h0005, 8'h00);
		regw(1'b1, 8'hff, 1'b1);
		regw(1'b0, 8'h00, 1'b0);
		move(1'b1, 5, 16'h0009, 8'h5a);
		for (int k = 0; k < 16; k++) begin
			lf = lfsr(lf);
			regw(1'b0, {5'h00, lf[2:0]}, 1'b0);
			move(1'b1, int'(lf[4:3]), lf[20:5], lf[28:21]);
			move(1'b0, int'(lf[30:29]), lf[20:5], 8'h00);
		end
		regw(1'b1, 8'h00, 1'b1);
		move(1'b0, 2, 16'h0009, 8'h00);
		conclude();
	end
endmodule : tb_xdas_ctrl
`default_nettype wire
